// >>> mfm_regs.svh
// Purpose: Register offsets, field positions, reset values and timing figures of the monitor
// Assumes: 20 MHz controller clock, APB byte addresses
// Notes: Times are held in milliseconds; tick counts derive from them
`ifndef MFM_REGS_SVH
`define MFM_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define MFM_OFS_STATUS 8'h00
`define MFM_OFS_ENABLE 8'h04
`define MFM_OFS_SPD_TARGET 8'h08
`define MFM_OFS_SPD_TOL 8'h0C
`define MFM_OFS_STATE 8'h10

// ==========================================================================
// Status and enable bit positions
`define MFM_BIT_START0 0
`define MFM_BIT_ROT0 6
`define MFM_BIT_REAR 12
`define MFM_BIT_CART 13
`define MFM_BIT_SUPPLY 14
`define MFM_BIT_DELIV 15
`define MFM_BIT_SCANNER 16
`define MFM_BIT_FEEDER 17
`define MFM_BIT_CONTROL 18
`define MFM_BIT_SUBSUPPLY 19
`define MFM_BIT_BELTFAN 20
`define MFM_NUM_BITS 21

// ==========================================================================
// Reset values
`define MFM_RST_ENABLE 21'h1FFFFF
`define MFM_RST_SPD_TARGET 16'h0FA0
`define MFM_RST_SPD_TOL 16'h00C8

// ==========================================================================
// Timing figures
`define MFM_CLK_NS 50
`define MFM_TICK_MS 1
`define MFM_START_MS 1500
`define MFM_ROT_MS 2000
`define MFM_FAN_LOCK_MS 10000
`define MFM_DELIV_BLANK_MS 100
`define MFM_DELIV_TEMP_MS 500
`define MFM_DELIV_RETRY_MS 4000

`endif

// >>> mfm_pkg.sv
// Purpose: Types shared by the motor and fan failure monitor
// Assumes: Nothing beyond the register header
// Notes: Structs carry the motor and fan pin groups
`default_nettype none

package mfm_pkg;
  // ========================================================================
  // Pin groups
  typedef struct packed {
    logic [5:0] drive; // 0..3 drums Y C M K, 4 fixing roller, 5 transfer belt
    logic [5:0] speed; // Speed feedback pulses, same order
  } mfm_motor_s;

  typedef struct packed {
    logic [3:0] drive; // 0 rear exhaust, 1 cartridge, 2 supply, 3 delivery
    logic [3:0] lock_timed; // Lock inputs, same order
    logic [5:0] lock_inst; // Scanner, feeder, control 1, control 2, sub supply, belt
  } mfm_fan_s;

  // ========================================================================
  // Delivery fan checker states
  typedef enum logic [2:0] {
    DF_IDLE = 3'b000,
    DF_BLANK = 3'b001,
    DF_WATCH = 3'b010,
    DF_RETRY = 3'b011,
    DF_FAILED = 3'b100
  } mfm_dstate_e;
endpackage : mfm_pkg

`default_nettype wire

// >>> mfm_monitor.sv
// Purpose: Motor speed and fan lock failure monitor with APB status registers
// Assumes: Drive inputs come from logic on clk; speed and lock inputs are pins
// Notes: Failures stay latched in STATUS until cleared by writing ones
//
// Notes on behaviour
// R1: Drum start-up failure if not locked 1.5 s
// R2: Drum rotation failure after 2 s irregular
// R3: Each colour drum checked with own timers
// R4: Fixing roller start-up failure after 1.5 s
// R5: Fixing roller rotation failure after 2 s irregular
// R6: Belt motor start-up failure after 1.5 s
// R7: Belt motor rotation failure after 2 s irregular
// R8: Rear exhaust fan failure after 10 s lock
// R9: Cartridge fan failure after 10 s lock
// R10: Delivery fan temporary lock: 0.5 s after 0.1 s
// R11: Temporary lock drives delivery fan 4 s retry
// R12: Lock held through retry gives delivery failure
// R13: Supply fan failure after 10 s lock
// R14: Scanner fan failure whenever lock asserted
// R15: Feeder fan failure whenever lock asserted
// R16: Either control fan lock gives control failure
// R17: Sub supply fan failure whenever lock asserted
// R18: Belt fan failure whenever lock asserted
// R19: Steppers and lifter motor are not monitored
// R20: Failures latched until cleared; common ms tick
// R21: Timers restart with drive; no flag when off
`timescale 1ns/1ns
`default_nettype none
`include "mfm_regs.svh"

module mfm_monitor #(
  parameter int unsigned TICK_CYCLES = (`MFM_TICK_MS * 1000000) / `MFM_CLK_NS
) (
  // Clock, reset, freeze
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored parts
  input wire mfm_pkg::mfm_motor_s motors,
  input wire mfm_pkg::mfm_fan_s fans,
  // Formatter side
  output logic delivery_retry_drive,
  output logic [20:0] error_status,
  output logic error_any
);

  // ==========================================================================
  // Constants
  localparam logic [13:0] START_TICKS = 14'(`MFM_START_MS / `MFM_TICK_MS);
  localparam logic [13:0] ROT_TICKS = 14'(`MFM_ROT_MS / `MFM_TICK_MS);
  localparam logic [13:0] LOCK_TICKS = 14'(`MFM_FAN_LOCK_MS / `MFM_TICK_MS);
  localparam logic [13:0] BLANK_TICKS = 14'(`MFM_DELIV_BLANK_MS / `MFM_TICK_MS);
  localparam logic [13:0] TEMP_TICKS = 14'(`MFM_DELIV_TEMP_MS / `MFM_TICK_MS);
  localparam logic [13:0] RETRY_TICKS = 14'(`MFM_DELIV_RETRY_MS / `MFM_TICK_MS);

  // Interval lands in target +/- tolerance
  function automatic logic in_window(input logic [15:0] iv, input logic [15:0] tgt,
                                     input logic [15:0] tol);
    logic [16:0] lo_sum;
    logic [16:0] hi;
    lo_sum = {1'b0, iv} + {1'b0, tol};
    hi = {1'b0, tgt} + {1'b0, tol};
    return (lo_sum >= {1'b0, tgt}) && ({1'b0, iv} <= hi);
  endfunction

  // Running interval already past the upper bound
  function automatic logic too_long(input logic [15:0] iv, input logic [15:0] tgt,
                                    input logic [15:0] tol);
    logic [16:0] hi;
    hi = {1'b0, tgt} + {1'b0, tol};
    return {1'b0, iv} > hi;
  endfunction

  // ==========================================================================
  // Registers and shared state
  logic [20:0] status;
  logic [20:0] enable;
  logic [15:0] spd_target;
  logic [15:0] spd_tol;
  logic [20:0] ev;
  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] s1, s2, s3, filt;
  logic [5:0] spd_f;
  logic [3:0] lock_t;
  logic [5:0] lock_i;
  logic ack_ok;
  logic wr_hit;
  logic [20:0] clr;
  logic mapped;
  logic [31:0] rd_mux;

  // ==========================================================================
  // Pin synchronisers: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 16'h0000;
      s2 <= 16'h0000;
      s3 <= 16'h0000;
      filt <= 16'h0000;
    end else if (ce) begin
      s1 <= {fans.lock_inst, fans.lock_timed, motors.speed};
      s2 <= s1;
      s3 <= s2;
      filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    end
  end

  assign spd_f = filt[5:0];
  assign lock_t = filt[9:6];
  assign lock_i = filt[15:10];

  // One shared millisecond tick for every timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h00000000;
    end else if (ce) begin
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h00000000 : tick_cnt + 32'h00000001; // R20
    end
  end

  assign tick = ce && (tick_cnt == TICK_CYCLES - 1);

  // ==========================================================================
  // Speed monitors: drums, fixing roller, belt motor only; steppers and lifter have none (R19)
  logic [15:0] icnt [0:5];
  logic [13:0] mtmr [0:5];
  logic [5:0] reached, last_ok, drive_q, pulse_q, edge_s, ok_now, start_ev, rot_ev;

  for (genvar i = 0; i < 6; i++) begin : g_mot
    assign edge_s[i] = spd_f[i] & ~pulse_q[i];
    // A pulse judges the interval just closed; between pulses an overlong gap is bad
    assign ok_now[i] = edge_s[i] ? in_window(icnt[i], spd_target, spd_tol)
                                 : (last_ok[i] && !too_long(icnt[i], spd_target, spd_tol));
    assign start_ev[i] = tick && drive_q[i] && motors.drive[i] && !reached[i] && enable[i] &&
                         !(edge_s[i] && ok_now[i]) && (mtmr[i] == START_TICKS - 14'h0001); // R1
    assign rot_ev[i] = tick && drive_q[i] && motors.drive[i] && reached[i] && !ok_now[i] &&
                       enable[i + 6] && (mtmr[i] == ROT_TICKS - 14'h0001); // R2

    // Per-motor timers, independent per channel; cleared while drive is off
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        icnt[i] <= 16'h0000;
        mtmr[i] <= 14'h0000;
        reached[i] <= 1'b0;
        last_ok[i] <= 1'b0;
        drive_q[i] <= 1'b0;
        pulse_q[i] <= 1'b0;
      end else if (ce) begin
        drive_q[i] <= motors.drive[i];
        pulse_q[i] <= spd_f[i];
        if (!motors.drive[i] || !drive_q[i]) begin // R21
          icnt[i] <= 16'h0000;
          mtmr[i] <= 14'h0000;
          reached[i] <= 1'b0;
          last_ok[i] <= 1'b0;
        end else begin
          icnt[i] <= edge_s[i] ? 16'h0001 : ((icnt[i] == 16'hFFFF) ? icnt[i] : icnt[i] + 16'h0001);
          if (edge_s[i]) begin
            last_ok[i] <= ok_now[i];
          end
          if (!reached[i]) begin
            if (edge_s[i] && ok_now[i]) begin // R3
              reached[i] <= 1'b1;
              mtmr[i] <= 14'h0000;
            end else if (tick && mtmr[i] != START_TICKS) begin
              mtmr[i] <= mtmr[i] + 14'h0001;
            end
          end else if (ok_now[i]) begin
            mtmr[i] <= 14'h0000;
          end else if (tick && mtmr[i] != ROT_TICKS) begin
            mtmr[i] <= mtmr[i] + 14'h0001;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Ten second lock timers: rear exhaust, cartridge, supply fan
  logic [13:0] ftmr [0:2];
  logic [2:0] fan_ev;

  for (genvar k = 0; k < 3; k++) begin : g_fan
    assign fan_ev[k] = tick && fans.drive[k] && lock_t[k] && (ftmr[k] == LOCK_TICKS - 14'h0001);
    // Any gap in the lock level restarts the count
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ftmr[k] <= 14'h0000;
      end else if (ce) begin
        if (!fans.drive[k] || !lock_t[k]) begin // R21
          ftmr[k] <= 14'h0000;
        end else if (tick && ftmr[k] != LOCK_TICKS) begin // R8 R9 R13
          ftmr[k] <= ftmr[k] + 14'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Delivery fan: blanking, temporary lock, retry drive, failure
  mfm_pkg::mfm_dstate_e dstate;
  logic [13:0] dtmr;
  logic deliv_ev;

  assign deliv_ev = tick && (dstate == mfm_pkg::DF_RETRY) && lock_t[3] && fans.drive[3] &&
                    (dtmr == RETRY_TICKS - 14'h0001); // R12
  assign delivery_retry_drive = (dstate == mfm_pkg::DF_RETRY); // R11

  // A lock that clears during the retry sends the checker back to watching
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dstate <= mfm_pkg::DF_IDLE;
      dtmr <= 14'h0000;
    end else if (ce) begin
      if (!fans.drive[3] || !enable[`MFM_BIT_DELIV]) begin // R21
        dstate <= mfm_pkg::DF_IDLE;
        dtmr <= 14'h0000;
      end else begin
        case (dstate)
          mfm_pkg::DF_IDLE: begin
            dstate <= mfm_pkg::DF_BLANK;
            dtmr <= 14'h0000;
          end
          mfm_pkg::DF_BLANK: begin
            if (tick && dtmr == BLANK_TICKS - 14'h0001) begin // R10
              dstate <= mfm_pkg::DF_WATCH;
              dtmr <= 14'h0000;
            end else if (tick) begin
              dtmr <= dtmr + 14'h0001;
            end
          end
          mfm_pkg::DF_WATCH: begin
            if (!lock_t[3]) begin
              dtmr <= 14'h0000;
            end else if (tick && dtmr == TEMP_TICKS - 14'h0001) begin // R10
              dstate <= mfm_pkg::DF_RETRY;
              dtmr <= 14'h0000;
            end else if (tick) begin
              dtmr <= dtmr + 14'h0001;
            end
          end
          mfm_pkg::DF_RETRY: begin
            if (!lock_t[3]) begin
              dstate <= mfm_pkg::DF_WATCH;
              dtmr <= 14'h0000;
            end else if (deliv_ev) begin // R12
              dstate <= mfm_pkg::DF_FAILED;
            end else if (tick) begin
              dtmr <= dtmr + 14'h0001;
            end
          end
          mfm_pkg::DF_FAILED: begin
            dtmr <= 14'h0000;
          end
          default: begin
            dstate <= mfm_pkg::DF_IDLE;
            dtmr <= 14'h0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Failure events, gated by the enable register
  always_comb begin
    ev = 21'h000000;
    ev[5:0] = start_ev; // R1 R4 R6
    ev[11:6] = rot_ev; // R2 R5 R7
    ev[`MFM_BIT_REAR] = fan_ev[0]; // R8
    ev[`MFM_BIT_CART] = fan_ev[1]; // R9
    ev[`MFM_BIT_SUPPLY] = fan_ev[2]; // R13
    ev[`MFM_BIT_DELIV] = deliv_ev; // R12
    ev[`MFM_BIT_SCANNER] = lock_i[0]; // R14
    ev[`MFM_BIT_FEEDER] = lock_i[1]; // R15
    ev[`MFM_BIT_CONTROL] = lock_i[2] | lock_i[3]; // R16
    ev[`MFM_BIT_SUBSUPPLY] = lock_i[4]; // R17
    ev[`MFM_BIT_BELTFAN] = lock_i[5]; // R18
    ev = ev & enable;
  end

  // ==========================================================================
  // APB decode; pready waits while frozen so no write is lost
  assign wr_hit = psel && penable && pready && pwrite;
  assign mapped = (paddr == `MFM_OFS_STATUS) || (paddr == `MFM_OFS_ENABLE) ||
                  (paddr == `MFM_OFS_SPD_TARGET) || (paddr == `MFM_OFS_SPD_TOL) ||
                  (paddr == `MFM_OFS_STATE);
  assign pready = psel && penable && ack_ok && ce;
  assign pslverr = pready && !mapped;
  assign clr = (wr_hit && paddr == `MFM_OFS_STATUS) ? pwdata[20:0] : 21'h000000;

  always_comb begin
    case (paddr)
      `MFM_OFS_STATUS: rd_mux = {11'h000, status};
      `MFM_OFS_ENABLE: rd_mux = {11'h000, enable};
      `MFM_OFS_SPD_TARGET: rd_mux = {16'h0000, spd_target};
      `MFM_OFS_SPD_TOL: rd_mux = {16'h0000, spd_tol};
      `MFM_OFS_STATE: rd_mux = {16'h0000, lock_i, 1'b0, dstate, reached};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle; the access then ends at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      ack_ok <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        prdata <= rd_mux;
        ack_ok <= 1'b1;
      end else if (pready) begin
        ack_ok <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable <= `MFM_RST_ENABLE;
      spd_target <= `MFM_RST_SPD_TARGET;
      spd_tol <= `MFM_RST_SPD_TOL;
    end else if (ce && wr_hit) begin
      if (paddr == `MFM_OFS_ENABLE) enable <= pwdata[20:0];
      if (paddr == `MFM_OFS_SPD_TARGET) spd_target <= pwdata[15:0];
      if (paddr == `MFM_OFS_SPD_TOL) spd_tol <= pwdata[15:0];
    end
  end

  // Sticky failures; a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= 21'h000000;
    end else if (ce) begin
      status <= (status & ~clr) | ev; // R20
    end
  end

  assign error_status = status;
  assign error_any = |status;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_start(int k);
    $rose(status[k]) |-> $past(motors.drive[k]) && !$past(reached[k]) &&
      ($past(mtmr[k]) == START_TICKS - 14'h0001);
  endproperty

  property p_rot(int k);
    $rose(status[k + 6]) |-> $past(reached[k]) && ($past(mtmr[k]) == ROT_TICKS - 14'h0001);
  endproperty

  property p_fan10(int k, int b);
    $rose(status[b]) |-> $past(lock_t[k]) && ($past(ftmr[k]) == LOCK_TICKS - 14'h0001);
  endproperty

  property p_inst(int k, int b);
    ce && lock_i[k] && enable[b] |=> status[b];
  endproperty

  sequence s_watch_locked;
    dstate == mfm_pkg::DF_WATCH && lock_t[3] && dtmr == TEMP_TICKS - 14'h0001 && tick;
  endsequence

  for (genvar i = 0; i < 4; i++) begin : g_chk
    a_drum_start: assert property (p_start(i)) else $error("drum start flag off time"); // R1
    a_drum_rot: assert property (p_rot(i)) else $error("drum rotation flag off time"); // R2
    a_drum_quiet: assert property (ce && !motors.drive[i] |=> mtmr[i] == 14'h0000 && // R3
      !reached[i]) else $error("drum timer not reset");
  end
  a_fuser_start: assert property (p_start(4)) else $error("fuser start flag off time"); // R4
  a_fuser_rot: assert property (p_rot(4)) else $error("fuser rotation flag off time"); // R5
  a_belt_start: assert property (p_start(5)) else $error("belt start flag off time"); // R6
  a_belt_rot: assert property (p_rot(5)) else $error("belt rotation flag off time"); // R7
  a_rear_lock: assert property (p_fan10(0, `MFM_BIT_REAR)) else $error("rear fan flag"); // R8
  a_cart_lock: assert property (p_fan10(1, `MFM_BIT_CART)) else $error("cartridge flag"); // R9
  a_temp_lock: assert property (s_watch_locked and (ce && fans.drive[3] && // R10
    enable[`MFM_BIT_DELIV]) |=> dstate == mfm_pkg::DF_RETRY)
    else $error("temporary lock not entered");
  a_retry_drive: assert property ($rose(delivery_retry_drive) |-> // R11
    $past(dstate) == mfm_pkg::DF_WATCH) else $error("retry drive without lock");
  a_deliv_fail: assert property ($rose(status[`MFM_BIT_DELIV]) |-> // R12
    $past(dstate) == mfm_pkg::DF_RETRY && $past(dtmr) == RETRY_TICKS - 14'h0001)
    else $error("delivery fail off time");
  a_supply_lock: assert property (p_fan10(2, `MFM_BIT_SUPPLY)) else $error("supply flag"); // R13
  a_scanner_lock: assert property (p_inst(0, `MFM_BIT_SCANNER)) else $error("scanner"); // R14
  a_feeder_lock: assert property (p_inst(1, `MFM_BIT_FEEDER)) else $error("feeder"); // R15
  a_control_lock: assert property (ce && lock_i[3] && enable[`MFM_BIT_CONTROL] |=> // R16
    status[`MFM_BIT_CONTROL]) else $error("control fan two missed");
  a_subsup_lock: assert property (p_inst(4, `MFM_BIT_SUBSUPPLY)) else $error("sub supply"); // R17
  a_beltfan_lock: assert property (p_inst(5, `MFM_BIT_BELTFAN)) else $error("belt fan"); // R18
  a_set_wins: assert property (ce && ev[`MFM_BIT_SCANNER] && clr[`MFM_BIT_SCANNER] |=> // R20
    status[`MFM_BIT_SCANNER]) else $error("event lost to clear");
  a_fan_off_quiet: assert property (ce && !fans.drive[0] |=> ftmr[0] == 14'h0000 [*1] ##1 // R21
    !$rose(status[`MFM_BIT_REAR])) else $error("rear fan timer while off");

endmodule // mfm_monitor

`default_nettype wire

// >>> mfm_spin_model.sv
// Purpose: Speed feedback model of the six monitored DC motors
// Assumes: One feedback pulse per PERIOD clocks while a motor spins
// Notes: A stopped motor leaves its feedback line low
`timescale 1ns/1ns
`default_nettype none

module mfm_spin_model #(
  parameter int PERIOD = 40
) (
  // Clock
  input wire logic clk,
  // Motor spin control and feedback
  input wire logic [5:0] run,
  output logic [5:0] speed
);
  // ==========================================================================
  // Pulse generator
  // Square wave, high for half a period: a one-clock pulse would never pass the
  // agreement filter behind the synchroniser. Shared phase is harmless, intervals are timed apart
  int cnt = 0;
  always_ff @(posedge clk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    speed <= (cnt < PERIOD / 2) ? run : 6'h00;
  end
endmodule // mfm_spin_model

`default_nettype wire

// >>> motor_fan_failure_monitor_tb.sv
// Purpose: Self-checking bench of the motor and fan failure monitor
// Assumes: Tick shortened to 4 clocks, so every ms limit scales with it
// Notes: Margins of tens of ticks absorb the 3-flop input synchronisers
`timescale 1ns/1ns
`default_nettype none
`include "mfm_regs.svh"

module motor_fan_failure_monitor_tb;
  localparam int TK = 4;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] mdrive = 6'h00;
  logic [5:0] run = 6'h00;
  wire logic [5:0] spd;
  mfm_pkg::mfm_fan_s fans = '0;
  logic retry;
  logic [20:0] status;
  logic any;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  // ==========================================================================
  // Design and motor model
  mfm_monitor #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .motors({mdrive, spd}),
    .fans(fans), .delivery_retry_drive(retry), .error_status(status), .error_any(any));
  mfm_spin_model #(.PERIOD(40)) spin_u (.clk(clk), .run(run), .speed(spd));

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(`MFM_OFS_STATUS, 32'h0, "status reset");
    rd(`MFM_OFS_ENABLE, `MFM_RST_ENABLE, "enable reset");
    rd(`MFM_OFS_SPD_TARGET, `MFM_RST_SPD_TARGET, "target reset");
    rd(`MFM_OFS_SPD_TOL, `MFM_RST_SPD_TOL, "tol reset");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped data", r, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    // Short interval keeps the run brief; model pulses every 40 clocks
    wr(`MFM_OFS_SPD_TARGET, 32'h28);
    wr(`MFM_OFS_SPD_TOL, 32'h4);
    rd(`MFM_OFS_SPD_TARGET, 32'h28, "target rw");
    $display("test regs done");
  endtask

  task automatic t_rot();
    mdrive <= 6'h3F;
    run <= 6'h3F;
    ticks(1600);
    chk("rot healthy", status, 32'h0);
    run <= 6'h00;
    ticks(1900);
    chk("rot early", status, 32'h0);
    ticks(200);
    chk("rot fail", status, 32'hFC0);
    chk("rot any", any, 1'b1);
    mdrive <= 6'h00;
    ticks(5);
    chk("rot latched", status, 32'hFC0);
    wr(`MFM_OFS_STATUS, 32'hFFF);
    rd(`MFM_OFS_STATUS, 32'h0, "rot cleared");
    ticks(20);
    chk("drive off quiet", status, 32'h0);
    $display("test rotation done");
  endtask

  task automatic t_start();
    run <= 6'b000101;
    mdrive <= 6'h3F;
    ticks(1400);
    chk("start early", status, 32'h0);
    ticks(200);
    chk("start fail", status, 32'h3A);
    chk("start fail", status, 32'h3A);
    mdrive <= 6'h00;
    run <= 6'h00;
    wr(`MFM_OFS_STATUS, 32'hFFF);
    $display("test startup done");
  endtask

  task automatic t_fans();
    fans.drive[2:0] <= 3'b111;
    fans.lock_timed[2:0] <= 3'b111;
    ticks(100);
    fans.lock_timed[1] <= 1'b0;
    ticks(2);
    fans.lock_timed[1] <= 1'b1;
    ticks(9798);
    chk("fan early", status, 32'h0);
    ticks(150);
    chk("fan rear supply", status, 32'h5000);
    ticks(150);
    chk("fan cartridge", status, 32'h7000);
    fans.lock_timed[2:0] <= 3'b000;
    fans.drive[2:0] <= 3'b000;
    wr(`MFM_OFS_STATUS, 32'h1FFFFF);
    $display("test fans done");
  endtask

  task automatic t_inst();
    int pos[6] = '{16, 17, 18, 18, 19, 20};
    for (int i = 0; i < 6; i++) begin
      fans.lock_inst <= 6'h01 << i;
      repeat (10) @(posedge clk);
      chk("inst fan", status, 32'h1 << pos[i]);
      // A clear landing while the lock is still up must lose to the event
      wr(`MFM_OFS_STATUS, 32'h1FFFFF);
      chk("inst held", status, 32'h1 << pos[i]);
      fans.lock_inst <= 6'h00;
      repeat (10) @(posedge clk);
      wr(`MFM_OFS_STATUS, 32'h1FFFFF);
    end
    // Masked scanner bit must stay clear
    wr(`MFM_OFS_ENABLE, 32'h1EFFFF);
    fans.lock_inst <= 6'h01;
    repeat (10) @(posedge clk);
    chk("inst masked", status, 32'h0);
    fans.lock_inst <= 6'h00;
    // Let the synchronised lock fall before unmasking, or it sets the bit late
    repeat (10) @(posedge clk);
    wr(`MFM_OFS_ENABLE, 32'h1FFFFF);
    // Frozen clock enable holds every flop, so a lock cannot reach status
    ce <= 1'b0;
    fans.lock_inst <= 6'h02;
    repeat (10) @(posedge clk);
    chk("frozen", status, 32'h0);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    chk("thawed", status, 32'h20000);
    fans.lock_inst <= 6'h00;
    repeat (10) @(posedge clk);
    wr(`MFM_OFS_STATUS, 32'h1FFFFF);
    $display("test instant fans done");
  endtask

  task automatic t_deliv();
    fans.drive[3] <= 1'b1;
    fans.lock_timed[3] <= 1'b1;
    ticks(580);
    chk("retry early", retry, 1'b0);
    ticks(40);
    chk("retry on", retry, 1'b1);
    ticks(3950);
    chk("deliv early", status, 32'h0);
    ticks(80);
    chk("deliv fail", status, 32'h8000);
    chk("retry off", retry, 1'b0);
    fans.drive[3] <= 1'b0;
    fans.lock_timed[3] <= 1'b0;
    $display("test delivery done");
  endtask

  // ==========================================================================
  // Verdict and hang guard
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ceiling sits above the roughly 81k cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_rot();
    t_start();
    t_fans();
    t_inst();
    t_deliv();
    tally_and_finish();
  end
endmodule // motor_fan_failure_monitor_tb

`default_nettype wire
